/* File: cpoc_pkg.sv */
// Shared constants for the configuration memory output controller
// Function
// - Chain enable low only when selected, gate high, and the stream is exhausted.
// - Chain enable returns high at once when gate falls or select rises.
// - Revision comes from the pick pins when the pick enable is low, else internal.
// - With the pick enable low, the two pick pins choose the revision, overriding the internal bits.
// - Undriven revision pick pins read as one.
// - Busy is honoured only in parallel mode without decompression.
// - While busy is high, address freezes and the data word holds.
// - First clock edge after busy falls presents the next address's word.
// - An undriven busy input reads as zero.
// - Clock out drives only when enabled, from oscillator or clock input.
// - Each source rising edge advances the address when data ready, selected, gated.
// - Each data word is valid at the rising edge of the clock out.
// - Clock out floats when select is high or gate is low.
// - With decompression, clock out parks high while data is not ready.
// - Test controller steps on test clock rising edges by mode select; undriven is one.
// - Test controller and test logic run on the test clock only.
// - Test data in shifts into the chosen register; undriven reads as one.
// - The chosen test register shifts out on test data out.
// - Gate low holds the address in reset and floats data and clock out.
// - Select high means standby: address reset, data and clock out float.
// - Configuration pulse rising edge samples the revision and reloads its start.
// - Clock input edges advance only when selected, gated, not busy, pulse high.
package cpoc_pkg;
  // Timing figures
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_HALF_NS   = 20;
  localparam int OSC_HALF_CYC  = OSC_HALF_NS / CLK_PERIOD_NS;
  localparam int EXT_HIGH_NS   = 40;
  localparam int EXT_HIGH_CYC  = (EXT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_NS        = 64;
  localparam int POR_CYC       = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;
  localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] EXT_LOAD = CNT_W'(EXT_HIGH_CYC);
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC);
  // Revision selection
  localparam int REV_COUNT = 4;
  localparam int REV_W     = 2;
  localparam logic [REV_W-1:0] REV_RST = 2'h3;
  // Synchronised pin group: field positions and idle levels
  localparam int PIN_W   = 7;
  localparam int PIN_CS  = 6;
  localparam int PIN_OE  = 5;
  localparam int PIN_CF  = 4;
  localparam int PIN_BSY = 3;
  localparam int PIN_EXT = 2;
  localparam int PIN_RP1 = 1;
  localparam int PIN_RP0 = 0;
  localparam logic [PIN_W-1:0] PIN_RST = 7'h53;
  // Test access port
  localparam int TAP_IR_W = 2;
  localparam int TAP_DR_W = 32;
  localparam logic [TAP_IR_W-1:0] IR_IDCODE  = 2'h1;
  localparam logic [TAP_IR_W-1:0] IR_BYPASS  = 2'h3;
  localparam logic [TAP_IR_W-1:0] IR_CAPTURE = 2'h1;
endpackage

/* File: cpoc_sync.sv */
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/10ps
`default_nettype none
module cpoc_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_bad
    $error("cpoc_sync: WIDTH must be at least 1");
  end

  // Stage one feeds only stage two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

/* File: cpoc_tap.sv */
// Test access port controller with identity and bypass registers
`timescale 1ns/10ps
`default_nettype none
module cpoc_tap
  import cpoc_pkg::*;
#(
  parameter logic [TAP_DR_W-1:0] ID_CODE = 32'h0A5C_0001 // Arbitrary value
) (
  input  wire logic tck,
  input  wire logic resetn,
  input  wire logic tms,
  input  wire logic tdi,
  output var  logic tdo,
  output var  logic tdoEn
);
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } cpoc_tap_t;

  cpoc_tap_t           state;
  logic [TAP_IR_W-1:0] ir;
  logic [TAP_IR_W-1:0] irShift;
  logic [TAP_DR_W-1:0] drShift;

  function automatic cpoc_tap_t tapNext(input cpoc_tap_t s, input logic m);
    unique case (s)
      TLR:     tapNext = m ? TLR : RTI;
      RTI:     tapNext = m ? SEL_DR : RTI;
      SEL_DR:  tapNext = m ? SEL_IR : CAP_DR;
      CAP_DR:  tapNext = m ? EX1_DR : SH_DR;
      SH_DR:   tapNext = m ? EX1_DR : SH_DR;
      EX1_DR:  tapNext = m ? UPD_DR : PA_DR;
      PA_DR:   tapNext = m ? EX2_DR : PA_DR;
      EX2_DR:  tapNext = m ? UPD_DR : SH_DR;
      UPD_DR:  tapNext = m ? SEL_DR : RTI;
      SEL_IR:  tapNext = m ? TLR : CAP_IR;
      CAP_IR:  tapNext = m ? EX1_IR : SH_IR;
      SH_IR:   tapNext = m ? EX1_IR : SH_IR;
      EX1_IR:  tapNext = m ? UPD_IR : PA_IR;
      PA_IR:   tapNext = m ? EX2_IR : PA_IR;
      EX2_IR:  tapNext = m ? UPD_IR : SH_IR;
      UPD_IR:  tapNext = m ? SEL_DR : RTI;
    endcase
  endfunction

  // Controller steps on the test clock alone
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      state <= TLR;
    end else begin
      state <= tapNext(state, tms);
    end
  end

  // Instruction path
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      ir      <= IR_IDCODE;
      irShift <= '0;
    end else begin
      if (state == TLR) ir <= IR_IDCODE;
      if (state == CAP_IR) irShift <= IR_CAPTURE;
      if (state == SH_IR) irShift <= {tdi, irShift[TAP_IR_W-1:1]};
      if (state == UPD_IR) ir <= irShift;
    end
  end

  // Data path; bypass is a single stage
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      drShift <= '0;
    end else if (state == CAP_DR) begin
      drShift <= (ir == IR_IDCODE) ? ID_CODE : '0;
    end else if (state == SH_DR) begin
      if (ir == IR_BYPASS) begin
        drShift <= {{(TAP_DR_W - 1){1'b0}}, tdi};
      end else begin
        drShift <= {tdi, drShift[TAP_DR_W-1:1]};
      end
    end
  end

  // Output changes on the falling edge so the far end samples it cleanly
  always_ff @(negedge tck or negedge resetn) begin
    if (!resetn) begin
      tdo   <= 1'b1;
      tdoEn <= 1'b0;
    end else begin
      tdo   <= (state == SH_IR) ? irShift[0] : drShift[0];
      tdoEn <= (state == SH_IR) || (state == SH_DR);
    end
  end
endmodule
`default_nettype wire

/* File: cpoc_top.sv */
// Output side of a configuration memory: stepping, flow control, clock and chain enable
`timescale 1ns/10ps
`default_nettype none
module cpoc_top
  import cpoc_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic                        linkClk,
  input  wire logic                        chipSelectN,
  input  wire logic                        outputGateIn,
  input  wire logic                        config_pulse_n,
  input  wire logic                        busy,
  input  wire logic                        external_revision_pick_en,
  input  wire logic                        revision_pick_0,
  input  wire logic                        revision_pick_1,
  input  wire logic [REV_W-1:0]            internalRevision,
  input  wire logic                        clockOutEnable,
  input  wire logic                        clockSourceInternal,
  input  wire logic                        parallelMode,
  input  wire logic                        decompressEnable,
  input  wire logic [DATA_W-1:0]           memData,
  input  wire logic                        memReady,
  input  wire logic [REV_COUNT*ADDR_W-1:0] revStartFlat,
  input  wire logic [REV_COUNT*ADDR_W-1:0] revLengthFlat,
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output var  logic [ADDR_W-1:0]           memAddr,
  output var  logic [DATA_W-1:0]           dataOut,
  output var  logic                        dataOutEn,
  output var  logic                        config_clock_out,
  output var  logic                        configClockOutEn,
  output var  logic                        chain_enable_out_n,
  output var  logic                        outputGateOut,
  output var  logic                        outputGateOe,
  output var  logic [REV_W-1:0]            activeRevision,
  output var  logic                        tdo,
  output var  logic                        tdoEn
);
  logic [PIN_W-1:0]  pinRaw;
  logic [PIN_W-1:0]  pinSync;
  logic              extToggle;
  logic              extToggleSync;
  logic              extToggleDelay;
  logic              cfDelay;
  logic [CNT_W-1:0]  oscCnt;
  logic              oscPhase;
  logic [CNT_W-1:0]  extHighCnt;
  logic [CNT_W-1:0]  porCnt;
  logic              pastLimit;
  logic              loadPending;
  logic              active;
  logic              cfHigh;
  logic              cfRise;
  logic              reload;
  logic              extTick;
  logic              oscRise;
  logic              srcTick;
  logic              busyHonoured;
  logic              advance;
  logic              exhausted;
  logic              hasBlocks;
  logic              next_oscPhase;
  logic              next_clockLevel;
  logic [REV_W-1:0]  pinRev;
  logic [REV_W-1:0]  selRev;
  logic [ADDR_W-1:0] startSel;
  logic [ADDR_W-1:0] startAct;
  logic [ADDR_W-1:0] lengthAct;
  logic [ADDR_W-1:0] last_address_limit;

  if (ADDR_W < 2 || DATA_W < 1 || OSC_HALF_CYC < 1) begin : g_bad
    $error("cpoc_top: widths or oscillator count out of range");
  end

  // Picks one revision's field out of a flat table
  function automatic logic [ADDR_W-1:0] revField(
    input logic [REV_COUNT*ADDR_W-1:0] flat,
    input logic [REV_W-1:0]            idx
  );
    revField = flat[idx*ADDR_W +: ADDR_W];
  endfunction

  // Pin levels cross into the system clock; idle levels model the pull resistors
  assign pinRaw = {chipSelectN, outputGateIn, config_pulse_n, busy,
                   external_revision_pick_en, revision_pick_1, revision_pick_0};

  cpoc_sync #(
    .WIDTH   (PIN_W),
    .RST_VAL (PIN_RST)
  ) u_pin_sync (
    .clk    (clk_sys),
    .resetn (resetn),
    .din    (pinRaw),
    .dout   (pinSync)
  );

  // Link side: each rising clock input edge flips one bit
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      extToggle <= 1'b0;
    end else begin
      extToggle <= ~extToggle;
    end
  end

  cpoc_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_edge_sync (
    .clk    (clk_sys),
    .resetn (resetn),
    .din    (extToggle),
    .dout   (extToggleSync)
  );

  // Edge detectors read only synchronised copies
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      extToggleDelay <= 1'b0;
      cfDelay        <= 1'b1;
    end else begin
      extToggleDelay <= extToggleSync;
      cfDelay        <= pinSync[PIN_CF];
    end
  end

  // Selection and gating terms
  assign active  = !pinSync[PIN_CS] && pinSync[PIN_OE];
  assign cfHigh  = pinSync[PIN_CF];
  assign cfRise  = cfHigh && !cfDelay;
  assign reload  = !active || cfRise;
  assign extTick = extToggleSync ^ extToggleDelay;

  // Revision source: pins when the enable is low, internal bits otherwise
  assign pinRev = {pinSync[PIN_RP1], pinSync[PIN_RP0]};
  assign selRev = pinSync[PIN_EXT] ? internalRevision : pinRev;

  // Table lookups; an empty revision has no words to give
  assign startSel           = revField(revStartFlat, selRev);
  assign startAct           = revField(revStartFlat, activeRevision);
  assign lengthAct          = revField(revLengthFlat, activeRevision);
  assign hasBlocks          = lengthAct != '0;
  assign last_address_limit = startAct + lengthAct - 1'b1;
  assign exhausted          = pastLimit || !hasBlocks;

  // Internal oscillator divided down from the system clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oscCnt   <= '0;
      oscPhase <= 1'b0;
    end else if (oscCnt == OSC_LAST) begin
      oscCnt   <= '0;
      oscPhase <= next_oscPhase;
    end else begin
      oscCnt   <= oscCnt + 1'b1;
    end
  end

  assign next_oscPhase = ~oscPhase;
  assign oscRise       = (oscCnt == OSC_LAST) && !oscPhase;

  // Selected clock source
  assign srcTick = clockSourceInternal ? oscRise : extTick;

  // Busy counts only in parallel mode without decompression
  assign busyHonoured = parallelMode && !decompressEnable
                        && pinSync[PIN_BSY];

  // Step condition; a word must be loaded before the next step
  assign advance = srcTick && active && cfHigh && !cfRise
                   && memReady && !loadPending
                   && !busyHonoured
                   && !exhausted;

  // Revision is sampled whenever the counter reloads
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      activeRevision <= REV_RST;
    end else if (reload) begin
      activeRevision <= selRev;
    end
  end

  // Address counter; it stays on the last word once the limit is passed
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      memAddr   <= '0;
      pastLimit <= 1'b0;
    end else if (reload) begin
      memAddr   <= startSel;
      pastLimit <= 1'b0;
    end else if (advance) begin
      if (memAddr == last_address_limit) begin
        pastLimit <= 1'b1;
      end else begin
        memAddr   <= memAddr + 1'b1;
      end
    end
  end

  // Output word loads after each step; busy blocks steps, so the word holds
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      loadPending <= 1'b1;
      dataOut     <= '0;
    end else if (reload || (advance && memAddr != last_address_limit)) begin
      loadPending <= 1'b1;
    end else if (loadPending && memReady) begin
      loadPending <= 1'b0;
      dataOut     <= memData;
    end
  end

  // High time of the clock out after a clock input edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      extHighCnt <= '0;
    end else if (extTick) begin
      extHighCnt <= EXT_LOAD;
    end else if (extHighCnt != '0) begin
      extHighCnt <= extHighCnt - 1'b1;
    end
  end

  // Rise of the clock out coincides with the step, so the held word is sampled
  always_comb begin
    if (decompressEnable && !memReady) begin
      next_clockLevel = 1'b1;
    end else if (clockSourceInternal) begin
      next_clockLevel = (oscCnt == OSC_LAST) ? next_oscPhase : oscPhase;
    end else begin
      next_clockLevel = extTick || (extHighCnt > 8'h01);
    end
  end

  // Pin drivers; enables drop as soon as the part is deselected or gated
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      config_clock_out <= 1'b1;
      configClockOutEn <= 1'b0;
      dataOutEn        <= 1'b0;
    end else begin
      config_clock_out <= next_clockLevel;
      configClockOutEn <= clockOutEnable && active;
      dataOutEn        <= active;
    end
  end

  // Chain enable hands over once this memory has nothing left
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chain_enable_out_n <= 1'b1;
    end else begin
      chain_enable_out_n <= !(active && exhausted);
    end
  end

  // Gate pin held low for a while after reset, like an internal power-on reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      porCnt        <= '0;
      outputGateOe  <= 1'b1;
      outputGateOut <= 1'b0;
    end else begin
      outputGateOut <= 1'b0;
      if (porCnt != POR_LAST) begin
        porCnt <= porCnt + 1'b1;
      end
      outputGateOe <= (porCnt != POR_LAST) && (porCnt + 1'b1 != POR_LAST);
    end
  end

  // Test access port on its own clock
  cpoc_tap u_tap (
    .tck    (tck),
    .resetn (resetn),
    .tms    (tms),
    .tdi    (tdi),
    .tdo    (tdo),
    .tdoEn  (tdoEn)
  );

  // Checks on the system clock
  ceo_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !chain_enable_out_n |-> $past(active) && $past(exhausted))
    else $error("chain enable low without exhaustion");

  ceo_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !active |=> chain_enable_out_n)
    else $error("chain enable not released");

  rev_pins_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reload && !pinSync[PIN_EXT] |=> activeRevision == $past(pinRev))
    else $error("pin revision not taken");

  rev_internal_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    reload && pinSync[PIN_EXT] |=> activeRevision == $past(internalRevision))
    else $error("internal revision not taken");

  busy_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    active && busyHonoured && !cfRise |=> $stable(memAddr) && $stable(pastLimit))
    else $error("address moved while busy");

  busy_ignored_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    srcTick && active && cfHigh && !cfRise && !parallelMode && memReady
    && !loadPending && !exhausted && memAddr != last_address_limit
    |=> memAddr == $past(memAddr) + 1'b1)
    else $error("step lost in serial mode");

  pins_float_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !active |=> !dataOutEn && !configClockOutEn)
    else $error("outputs driven while idle");

  park_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    active && clockOutEnable && decompressEnable && !memReady
    |=> config_clock_out && configClockOutEn)
    else $error("clock out not parked high");

  cf_reload_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfRise |=> memAddr == $past(startSel) && !pastLimit && loadPending)
    else $error("pulse did not reload start");

  step_edge_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    advance |=> config_clock_out)
    else $error("clock out not high at step");
endmodule
`default_nettype wire

/* File: cpoc_fpga_model.sv */
// Far-side model: configuration receiver busy and next cascaded memory select
`timescale 1ns/10ps
`default_nettype none
module cpoc_fpga_model (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic stall,
  input  wire logic chainEnN,
  output var  logic busy,
  output var  logic nextSelectN
);
  // Next memory is selected by this one's chain enable
  assign nextSelectN = chainEnN;
  // Busy changes just after an edge; reads low out of reset like the pull-down
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else begin
      busy <= stall;
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the configuration output controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cpoc_pkg::*;
  logic        clk_sys = 0, resetn = 0, linkClk = 0, linkRun = 0, stall;
  logic        chipSelectN, outputGateIn, config_pulse_n, busy, memReady, nextSelN;
  logic        external_revision_pick_en, revision_pick_0, revision_pick_1;
  logic        clockOutEnable, clockSourceInternal, parallelMode, decompressEnable;
  logic        tck, tms, tdi, tdo, tdoEn, dataOutEn, config_clock_out, configClockOutEn;
  logic        chain_enable_out_n, outputGateOut, outputGateOe;
  logic [1:0]  internalRevision, activeRevision, r;
  logic [7:0]  memData, dataOut, d;
  logic [15:0] memAddr, a;
  logic [63:0] revStartFlat, revLengthFlat;
  logic [31:0] seed = 32'h91663153;
  int          n_mismatch = 0, total_checks = 0;
  // Link clock offset so its edges never meet the system clock
  always #2 clk_sys = ~clk_sys;
  always #62.53 linkClk = linkRun & ~linkClk;
  assign memData = word(memAddr);
  cpoc_top #(.ADDR_W(16), .DATA_W(8)) cpoc_top_inst (.clk_sys, .resetn, .linkClk,
    .chipSelectN, .outputGateIn, .config_pulse_n, .busy, .external_revision_pick_en,
    .revision_pick_0, .revision_pick_1, .internalRevision, .clockOutEnable,
    .clockSourceInternal, .parallelMode, .decompressEnable, .memData, .memReady,
    .revStartFlat, .revLengthFlat, .tck, .tms, .tdi, .memAddr, .dataOut, .dataOutEn,
    .config_clock_out, .configClockOutEn, .chain_enable_out_n, .outputGateOut,
    .outputGateOe, .activeRevision, .tdo, .tdoEn);
  cpoc_fpga_model cpoc_fpga_model_inst (.clk_sys, .resetn, .stall,
    .chainEnN(chain_enable_out_n), .busy, .nextSelectN(nextSelN));
  function automatic logic [7:0] word(input logic [15:0] x);
    return x[7:0] ^ 8'hA5;
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] st(input logic [1:0] x);
    return revStartFlat[16*x +: 16];
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Inputs set after this task change half a nanosecond after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #0.5;
  endtask
  // Bounded wait for n link clock rises, then let the step settle
  task automatic step(input int n);
    int k;
    repeat (n) begin
      k = 0;
      while (linkClk !== 1'b0 && k < 100) begin cyc(1); k++; end
      while (linkClk !== 1'b1 && k < 100) begin cyc(1); k++; end
      if (k >= 100) begin n_mismatch++; final_report(); end
    end
    cyc(8);
  endtask
  task automatic reload();
    config_pulse_n = 0;
    cyc(6);
    config_pulse_n = 1;
    cyc(8);
  endtask
  // One test clock period; mode and data change while the clock is low
  task automatic tckp(input logic m, input logic i);
    tms = m;
    tdi = i;
    #10 tck = 1;
    #10 tck = 0;
    #1;
  endtask
  initial begin #400000; n_mismatch++; final_report(); end
  initial begin
    {chipSelectN, outputGateIn, config_pulse_n, stall, memReady} = 5'h1D;
    {external_revision_pick_en, revision_pick_1, revision_pick_0} = 3'h3;
    {clockOutEnable, clockSourceInternal, parallelMode, decompressEnable} = 4'hA;
    {tck, tms, tdi, internalRevision} = 5'h0C;
    // Random starts; revision 0 holds no blocks
    for (int i = 0; i < 4; i++) begin
      revStartFlat[16*i +: 16] = 16'(i * 16'h1000 + rnd() % 16'h100);
      revLengthFlat[16*i +: 16] = 16'(i * 3);
    end
    repeat (10) @(posedge clk_sys);
    #0.5 resetn = 1;
    chipSelectN = 0;
    chk("gate hold", outputGateOe, 1);
    cyc(24);
    chk("gate free", {outputGateOe, outputGateOut}, 0);
    // Every revision through pins and through internal bits
    for (int m = 0; m < 8; m++) begin
      external_revision_pick_en = m[2];
      {revision_pick_1, revision_pick_0} = m[1:0];
      internalRevision = ~m[1:0];
      r = m[2] ? ~m[1:0] : m[1:0];
      reload();
      chk("revision", activeRevision, r);
      chk("start", memAddr, st(r));
      chk("chain", chain_enable_out_n, r != 0);
    end
    // Revision 3 from the pins; link clock stood still until now
    {external_revision_pick_en, revision_pick_1, revision_pick_0} = 3'h3;
    reload();
    chk("pins rev", activeRevision, 2'h3);
    linkRun = 1;
    // Stepping on link edges: revision 3, nine words
    a = memAddr;
    r = 2'(rnd() % 3 + 1);
    step(r);
    chk("advance", memAddr, a + r);
    chk("word", dataOut, word(memAddr));
    chk("drive", dataOutEn, 1);
    a = memAddr;
    d = dataOut;
    stall = 1;
    step(2);
    chk("busy addr", memAddr, a);
    chk("busy word", dataOut, d);
    stall = 0;
    step(1);
    chk("after busy", {memAddr, dataOut}, {a + 16'h1, word(a + 16'h1)});
    // Busy ignored in serial mode and with decompression
    stall = 1;
    parallelMode = 0;
    step(1);
    chk("serial", memAddr, a + 16'h2);
    {parallelMode, decompressEnable} = 2'h3;
    step(1);
    chk("decomp", memAddr, a + 16'h3);
    {stall, memReady} = 2'h0;
    step(2);
    cyc(8);
    chk("not ready", memAddr, a + 16'h3);
    chk("park high", config_clock_out, 1);
    {memReady, decompressEnable} = 2'h2;
    // Oscillator source runs the stream to its end
    clockSourceInternal = 1;
    cyc(300);
    chk("chain end", chain_enable_out_n, 0);
    chk("next select", nextSelN, 0);
    clockSourceInternal = 0;
    outputGateIn = 0;
    cyc(6);
    chk("gate chain", chain_enable_out_n, 1);
    chk("gate float", {configClockOutEn, dataOutEn}, 0);
    chk("gate addr", memAddr, st(2'h3));
    outputGateIn = 1;
    cyc(6);
    step(1);
    chipSelectN = 1;
    cyc(6);
    chk("desel chain", chain_enable_out_n, 1);
    chk("desel float", {configClockOutEn, dataOutEn}, 0);
    chk("desel addr", memAddr, st(2'h3));
    {chipSelectN, clockOutEnable} = 2'h0;
    cyc(8);
    chk("clk off", configClockOutEn, 0);
    clockOutEnable = 1;
    cyc(8);
    chk("clk on", configClockOutEn, 1);
    // Test port: capture of the instruction, then bypass
    tckp(0, 1);
    tckp(1, 1);
    tckp(1, 1);
    tckp(0, 1);
    tckp(0, 1);
    chk("ir shift en", {tdoEn, tdo}, 2'h3);
    tckp(0, 1);
    chk("ir bit1", tdo, 0);
    tckp(1, 1);
    chk("ir exit", tdoEn, 0);
    tckp(1, 1);
    tckp(0, 1);
    tckp(1, 0);
    tckp(0, 0);
    tckp(0, 0);
    chk("bypass cap", tdo, 0);
    tckp(0, 1);
    chk("bypass tdi", tdo, 1);
    final_report();
  end
endmodule
`default_nettype wire
